// ===== logic/ddpot_slave.sv
// Two-wire serial slave controlling two digitally set potentiometers.
// What this block does
// - Capture SDA bits on rising SCL.
// - Change driven SDA only after SCL falls.
// - SDA is open drain: pull low or release.
// - Acknowledge only on exact address match.
// - Volatile wiper position register per potentiometer.
// - Reset recalls default saved setting into wiper.
// - Four host readable, writable saved settings each.
// - Two independent potentiometer channels.
// - Wiper decodes to exactly one tap.
// - Write protect low blocks saved-setting writes.
// - No address acknowledge during nonvolatile write.
`timescale 1ns/1ns
module ddpot_slave #(
	parameter logic [3:0] ID_CODE   = 4'h3, // Arbitrary value.
	parameter int         NV_CYCLES = ddpot_pkg::NV_WRITE_CYCLES
) (
	// System.
	input  wire logic                   CLK,
	input  wire logic                   SYS_RST,
	// Two-wire link.
	input  wire logic                   SCL,
	input  wire logic                   SDA_I,
	output logic                        SDA_O,
	output logic                        SDA_OE,
	// Straps and protection.
	input  wire logic [3:0]             ADDR_SEL,
	input  wire logic                   WP_N,
	// Potentiometer controls.
	output logic [1:0][7:0]             WIPER,
	output logic [1:0][255:0]           TAP_SEL,
	output logic                        NV_BUSY
);

	// The write timer is NV_CNT_W bits wide, so longer write times cannot be counted.
	if (NV_CYCLES < 1 || NV_CYCLES >= (1 << ddpot_pkg::NV_CNT_W)) begin : g_bad_cycles
		$error("NV_CYCLES out of range");
	end

	function automatic logic [255:0] tap_decode(input logic [7:0] w);
		tap_decode = 256'h1 << w;
	endfunction : tap_decode

	// Link domain: the bit is held from one SCL rise to the next, so the system
	// domain may read it once the synchronised rise has been seen.
	logic link_bit;
	logic next_link_bit;
	always_comb next_link_bit = SDA_I;
	always_ff @(posedge SCL) begin
		link_bit <= next_link_bit;
	end

	// Synchronisers.
	logic [2:0] scl_s;
	logic [2:0] sda_s;
	logic [1:0] wp_s;
	logic [3:0] addr_s1;
	logic [3:0] addr_s2;
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			scl_s   <= 3'h7;
			sda_s   <= 3'h7;
			wp_s    <= 2'h0;
			addr_s1 <= 4'h0;
			addr_s2 <= 4'h0;
		end else begin
			scl_s   <= {scl_s[1:0], SCL};
			sda_s   <= {sda_s[1:0], SDA_I};
			wp_s    <= {wp_s[0], WP_N};
			addr_s1 <= ADDR_SEL;
			addr_s2 <= addr_s1;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	assign scl_rise = scl_s[1] & ~scl_s[2];
	assign scl_fall = ~scl_s[1] & scl_s[2];
	assign start_ev = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
	assign stop_ev  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

	// Main state.
	ddpot_pkg::ddpot_state_t state, next_state;
	logic [3:0]                    cnt, next_cnt;
	logic [1:0]                    byte_no, next_byte_no;
	logic [7:0]                    shreg, next_shreg;
	logic                          oe, next_oe;
	ddpot_pkg::ddpot_instr_t       instr, next_instr;
	logic [1:0][7:0]               wiper, next_wiper;
	logic [1:0][3:0][7:0]          dr, next_dr;
	logic                          recall, next_recall;
	logic                          pend, next_pend;
	logic [7:0]                    pend_val, next_pend_val;
	logic                          busy, next_busy;
	logic [ddpot_pkg::NV_CNT_W-1:0] nv_cnt, next_nv_cnt;

	ddpot_pkg::ddpot_instr_t cur;
	logic                    id_match;
	logic                    op_ok;
	logic                    ack_ok;
	logic [7:0]              rd_val;
	assign cur      = ddpot_pkg::ddpot_instr_t'({shreg[7:2], shreg[0]});
	assign id_match = shreg[ddpot_pkg::ID_MSB:ddpot_pkg::ID_LSB] == ID_CODE
		&& shreg[ddpot_pkg::ADDR_MSB:ddpot_pkg::ADDR_LSB] == addr_s2;
	assign op_ok    = cur.op == ddpot_pkg::OP_RD_WIPER || cur.op == ddpot_pkg::OP_WR_WIPER
		|| cur.op == ddpot_pkg::OP_RD_SAVED || cur.op == ddpot_pkg::OP_WR_SAVED;
	assign rd_val   = (cur.op == ddpot_pkg::OP_RD_WIPER) ? wiper[cur.pot] : dr[cur.pot][cur.idx];

	always_comb begin
		unique case (byte_no)
			2'd0:    ack_ok = id_match && !busy;
			2'd1:    ack_ok = op_ok;
			default: ack_ok = 1'b1;
		endcase
	end

	always_comb begin
		next_state    = state;
		next_cnt      = cnt;
		next_byte_no  = byte_no;
		next_shreg    = shreg;
		next_oe       = oe;
		next_instr    = instr;
		next_wiper    = wiper;
		next_dr       = dr;
		next_recall   = 1'b0;
		next_pend     = pend;
		next_pend_val = pend_val;
		next_busy     = busy;
		next_nv_cnt   = nv_cnt;
		if (recall) begin
			for (int p = 0; p < ddpot_pkg::N_POT; p++) begin
				next_wiper[p] = dr[p][0];
			end
		end
		if (busy) begin
			if (nv_cnt == '0)
				next_busy = 1'b0;
			else
				next_nv_cnt = nv_cnt - 1'b1;
		end
		if (start_ev) begin
			next_state   = ddpot_pkg::ST_RX;
			next_cnt     = 4'h0;
			next_byte_no = 2'd0;
			next_oe      = 1'b0;
			next_pend    = 1'b0;
		end else if (stop_ev) begin
			next_state = ddpot_pkg::ST_IDLE;
			next_oe    = 1'b0;
			next_pend  = 1'b0;
			if (pend && wp_s[1]) begin
				next_dr[instr.pot][instr.idx] = pend_val;
				next_busy   = 1'b1;
				next_nv_cnt = ddpot_pkg::NV_CNT_W'(NV_CYCLES - 1);
			end
		end else begin
			unique case (state)
				ddpot_pkg::ST_IDLE: begin
				end
				ddpot_pkg::ST_RX: begin
					if (scl_rise && cnt != 4'h8) begin
						next_shreg = {shreg[6:0], link_bit};
						next_cnt   = cnt + 4'h1;
					end else if (scl_fall && cnt == 4'h8) begin
						next_state = ddpot_pkg::ST_ACK;
						next_oe    = ack_ok;
					end
				end
				ddpot_pkg::ST_ACK: begin
					if (scl_fall) begin
						next_oe    = 1'b0;
						next_cnt   = 4'h0;
						next_state = ddpot_pkg::ST_RX;
						if (!oe) begin
							next_state = ddpot_pkg::ST_IDLE;
						end else if (byte_no == 2'd0) begin
							next_byte_no = 2'd1;
						end else if (byte_no == 2'd1) begin
							next_instr   = cur;
							next_byte_no = 2'd2;
							if (cur.op == ddpot_pkg::OP_RD_WIPER
								|| cur.op == ddpot_pkg::OP_RD_SAVED) begin
								next_state = ddpot_pkg::ST_TX;
								next_shreg = rd_val;
								next_oe    = ~rd_val[7];
								next_cnt   = 4'h1;
							end
						end else begin
							next_state = ddpot_pkg::ST_IDLE;
							if (instr.op == ddpot_pkg::OP_WR_WIPER) begin
								next_wiper[instr.pot] = shreg;
							end else begin
								next_pend     = 1'b1;
								next_pend_val = shreg;
							end
						end
					end
				end
				ddpot_pkg::ST_TX: begin
					if (scl_fall) begin
						if (cnt == 4'h8) begin
							next_oe    = 1'b0;
							next_state = ddpot_pkg::ST_TACK;
						end else begin
							next_shreg = {shreg[6:0], 1'b0};
							next_oe    = ~shreg[6];
							next_cnt   = cnt + 4'h1;
						end
					end
				end
				ddpot_pkg::ST_TACK: begin
					// The master's acknowledge ends a read; only one byte is sent.
					if (scl_fall)
						next_state = ddpot_pkg::ST_IDLE;
				end
				default: next_state = ddpot_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state    <= ddpot_pkg::ST_IDLE;
			cnt      <= 4'h0;
			byte_no  <= 2'd0;
			shreg    <= 8'h00;
			oe       <= 1'b0;
			instr    <= '0;
			wiper    <= {ddpot_pkg::N_POT{ddpot_pkg::WIPER_RESET}};
			dr       <= {(ddpot_pkg::N_POT * ddpot_pkg::N_SAVED){ddpot_pkg::SAVED_RESET}};
			recall   <= 1'b1;
			pend     <= 1'b0;
			pend_val <= 8'h00;
			busy     <= 1'b0;
			nv_cnt   <= '0;
			SDA_O    <= 1'b0;
		end else begin
			state    <= next_state;
			cnt      <= next_cnt;
			byte_no  <= next_byte_no;
			shreg    <= next_shreg;
			oe       <= next_oe;
			instr    <= next_instr;
			wiper    <= next_wiper;
			dr       <= next_dr;
			recall   <= next_recall;
			pend     <= next_pend;
			pend_val <= next_pend_val;
			busy     <= next_busy;
			nv_cnt   <= next_nv_cnt;
			SDA_O    <= 1'b0;
		end
	end

	assign SDA_OE  = oe;
	assign WIPER   = wiper;
	assign NV_BUSY = busy;

	// Taps are registered from the next wiper value so they track WIPER exactly.
	for (genvar p = 0; p < ddpot_pkg::N_POT; p++) begin : g_tap
		always_ff @(posedge CLK) begin
			if (SYS_RST)
				TAP_SEL[p] <= tap_decode(ddpot_pkg::WIPER_RESET);
			else
				TAP_SEL[p] <= tap_decode(next_wiper[p]);
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	chk_oe_scl_low: assert property ($rose(SDA_OE) |-> !scl_s[2])
		else $error("SDA drive started while SCL high");
	chk_open_drain: assert property (SDA_O == 1'b0)
		else $error("SDA driven high");
	chk_addr_nack: assert property (state == ddpot_pkg::ST_RX && cnt == 4'h8 && scl_fall
		&& byte_no == 2'd0 && !id_match && !start_ev && !stop_ev |=> !SDA_OE)
		else $error("Acknowledged a foreign address");
	chk_tap_onehot: assert property ($onehot(TAP_SEL[0]) && $onehot(TAP_SEL[1]))
		else $error("Tap select not one-hot");
	chk_power_recall: assert property ($fell(recall) |-> WIPER[0] == dr[0][0]
		&& WIPER[1] == dr[1][0])
		else $error("Wiper not recalled from default setting");
	chk_wp_block: assert property (!wp_s[1] |=> $stable(dr))
		else $error("Saved setting changed under write protect");
	chk_busy_nack: assert property (busy && state == ddpot_pkg::ST_RX && cnt == 4'h8
		&& byte_no == 2'd0 && scl_fall && !start_ev && !stop_ev |=> !SDA_OE)
		else $error("Address acknowledged during write");
	chk_busy_hold: assert property ($rose(busy) |-> busy [*8])
		else $error("Write time too short");
	chk_bit_take: assert property (state == ddpot_pkg::ST_RX && scl_rise && cnt != 4'h8
		&& !start_ev && !stop_ev |=> shreg[0] == $past(link_bit) ##0 cnt == $past(cnt) + 4'h1)
		else $error("Bit not captured on SCL rise");
	chk_wiper_write: assert property (state == ddpot_pkg::ST_ACK && scl_fall && oe
		&& byte_no == 2'd2 && instr.op == ddpot_pkg::OP_WR_WIPER && !start_ev && !stop_ev
		|=> ##1 TAP_SEL[instr.pot] == tap_decode($past(shreg, 2)))
		else $error("Wiper write did not reach taps");

	cov_start: cover property (start_ev);
	cov_read: cover property (state == ddpot_pkg::ST_TACK && scl_fall);
	cov_nv_write: cover property ($rose(busy));

endmodule : ddpot_slave

// ===== logic/ddpot_pkg.sv
// Shared constants and types for the dual digital potentiometer serial slave.
package ddpot_pkg;

	localparam int DATA_W    = 8;
	localparam int N_POT     = 2;
	localparam int N_SAVED   = 4;
	localparam int N_TAPS    = 256;
	localparam int BITS_BYTE = 8;

	// Identification byte layout.
	localparam int ID_MSB   = 7;
	localparam int ID_LSB   = 4;
	localparam int ADDR_MSB = 3;
	localparam int ADDR_LSB = 0;

	// Instruction opcodes, upper nibble of the instruction byte.
	localparam logic [3:0] OP_RD_WIPER = 4'h9;
	localparam logic [3:0] OP_WR_WIPER = 4'ha;
	localparam logic [3:0] OP_RD_SAVED = 4'hb;
	localparam logic [3:0] OP_WR_SAVED = 4'hc;

	// Reset contents.
	localparam logic [7:0] SAVED_RESET = 8'h80;
	localparam logic [7:0] WIPER_RESET = 8'h00;

	// Nonvolatile write time.
	localparam int CLK_HZ          = 125_000_000;
	localparam int NV_WRITE_MS     = 5;
	localparam int NV_WRITE_CYCLES = NV_WRITE_MS * (CLK_HZ / 1000);
	localparam int NV_CNT_W        = 20;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX   = 3'b001,
		ST_ACK  = 3'b010,
		ST_TX   = 3'b011,
		ST_TACK = 3'b100
	} ddpot_state_t;

	// Instruction byte: opcode, saved-setting index, potentiometer select.
	typedef struct packed {
		logic [3:0] op;
		logic [1:0] idx;
		logic       pot;
	} ddpot_instr_t;

endpackage : ddpot_pkg

// ===== bench/ddpot_master.sv
// Two-wire bus master model that supplies the serial clock.
`timescale 1ns/1ns
module ddpot_master (
	// Link clock and wire.
	input  wire logic LCLK,
	input  wire logic SDA,
	output logic      SCL,
	output logic      SDA_LOW
);
	initial begin
		SCL = 1'b1;
		SDA_LOW = 1'b0;
	end
	// Four link ticks per phase keep each phase well above the slave's minimum.
	task automatic half;
		repeat (4) @(posedge LCLK);
	endtask : half
	task automatic start;
		half;
		SDA_LOW <= 1'b1;
		half;
		SCL <= 1'b0;
	endtask : start
	// Data moves only while SCL is low, so SCL stands still between frames.
	task automatic bitx(input logic b, output logic r);
		half;
		SDA_LOW <= ~b;
		half;
		SCL <= 1'b1;
		half;
		r = SDA;
		SCL <= 1'b0;
	endtask : bitx
	task automatic xfer(input logic [7:0] w, output logic [7:0] r, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bitx(w[i], r[i]);
		end
		bitx(1'b1, a);
		ack = ~a;
	endtask : xfer
	task automatic stop;
		half;
		SDA_LOW <= 1'b1;
		half;
		SCL <= 1'b1;
		half;
		SDA_LOW <= 1'b0;
		half;
	endtask : stop
endmodule : ddpot_master

// ===== bench/ddpot_slave_tb.sv
// Self-checking bench for the dual potentiometer serial slave.
`timescale 1ns/1ns
module ddpot_slave_tb;
	localparam logic [3:0] ID = 4'h3; // Arbitrary value.
	logic              clk      = 1'b0;
	logic              lclk     = 1'b0;
	logic              sys_rst  = 1'b1;
	logic [3:0]        addr_sel = 4'h5;
	logic              wp_n     = 1'b1;
	logic              oe_q     = 1'b0;
	logic              scl;
	logic              sda_low;
	logic              sda_o;
	logic              sda_oe;
	logic              nv_busy;
	logic [1:0][7:0]   wiper;
	logic [1:0][255:0] tap_sel;
	wire               sda;
	int                errors    = 0;
	int                tests_run = 0;
	assign sda = ~(sda_low | sda_oe);
	always #4 clk = ~clk;
	always #15 lclk = ~lclk;
	ddpot_slave #(.ID_CODE(ID), .NV_CYCLES(1000)) dut (.CLK(clk), .SYS_RST(sys_rst),
		.SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .ADDR_SEL(addr_sel),
		.WP_N(wp_n), .WIPER(wiper), .TAP_SEL(tap_sel), .NV_BUSY(nv_busy));
	ddpot_master m (.LCLK(lclk), .SDA(sda), .SCL(scl), .SDA_LOW(sda_low));
	task automatic fail(input logic [255:0] g, input logic [255:0] e);
		errors++;
		$display("mismatch at %0t: got %h expected %h", $time, g, e);
	endtask : fail
	task automatic cmp1(input logic g, input logic e);
		tests_run++;
		if (g !== e) fail(g, e);
	endtask : cmp1
	task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) fail(g, e);
	endtask : cmp8
	task automatic cmp_tap(input logic [255:0] g, input logic [255:0] e);
		tests_run++;
		if (g !== e) fail(g, e);
	endtask : cmp_tap
	// The device may only move SDA while SCL is low, and only ever pulls it low.
	always @(posedge clk) begin
		oe_q <= sda_oe;
		if (!sys_rst && scl === 1'b1 && sda_oe !== oe_q) fail(sda_oe, oe_q);
		if (sda_oe === 1'b1 && sda_o !== 1'b0) fail(sda_o, 1'b0);
	end
	task automatic op(input logic [3:0] o, input logic [1:0] x, input logic p,
		input logic [7:0] d, output logic [7:0] r, output logic ok);
		logic [7:0] j;
		logic       a1;
		logic       a2;
		logic       a3;
		m.start;
		m.xfer({ID, 4'h5}, j, a1);
		m.xfer({o, x, 1'b0, p}, j, a2);
		m.xfer(d, r, a3);
		m.stop;
		ok = a1 & a2;
	endtask : op
	task automatic poll(output logic ok);
		logic [7:0] j;
		m.start;
		m.xfer({ID, 4'h5}, j, ok);
		m.stop;
	endtask : poll
	task automatic t_reset;
		for (int p = 0; p < 2; p++) begin
			cmp8(wiper[p], ddpot_pkg::SAVED_RESET);
			cmp_tap(tap_sel[p], 256'h1 << ddpot_pkg::SAVED_RESET);
		end
		$display("test reset done");
	endtask : t_reset
	task automatic t_wiper;
		logic [7:0] r;
		logic       ok;
		op(ddpot_pkg::OP_WR_WIPER, 2'd0, 1'b0, 8'h96, r, ok);
		cmp1(ok, 1'b1);
		op(ddpot_pkg::OP_WR_WIPER, 2'd0, 1'b1, 8'hff, r, ok);
		cmp8(wiper[0], 8'h96);
		cmp8(wiper[1], 8'hff);
		cmp_tap(tap_sel[0], 256'h1 << 8'h96);
		cmp_tap(tap_sel[1], 256'h1 << 8'hff);
		op(ddpot_pkg::OP_RD_WIPER, 2'd0, 1'b0, 8'hff, r, ok);
		cmp8(r, 8'h96);
		op(ddpot_pkg::OP_RD_WIPER, 2'd0, 1'b1, 8'hff, r, ok);
		cmp8(r, 8'hff);
		$display("test wiper done");
	endtask : t_wiper
	task automatic t_addr;
		logic [7:0] r;
		logic       ok;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) addr_sel <= 4'h5 ^ (4'h1 << i);
			op(ddpot_pkg::OP_RD_WIPER, 2'd0, 1'b0, 8'hff, r, ok);
			cmp1(ok, 1'b0);
		end
		@(posedge clk) addr_sel <= 4'h5;
		op(4'h0, 2'd0, 1'b0, 8'hff, r, ok);
		cmp1(ok, 1'b0);
		$display("test address done");
	endtask : t_addr
	task automatic t_saved;
		logic [7:0] r;
		logic       ok;
		int         n;
		op(ddpot_pkg::OP_WR_SAVED, 2'd2, 1'b1, 8'h5a, r, ok);
		cmp1(nv_busy, 1'b1);
		poll(ok);
		cmp1(ok, 1'b0);
		n = 0;
		do begin
			poll(ok);
			n++;
		end while (!ok && n < 20);
		cmp1(ok, 1'b1);
		for (int x = 0; x < 4; x++) begin
			op(ddpot_pkg::OP_RD_SAVED, 2'(x), 1'b1, 8'hff, r, ok);
			cmp8(r, x == 2 ? 8'h5a : ddpot_pkg::SAVED_RESET);
		end
		op(ddpot_pkg::OP_RD_SAVED, 2'd2, 1'b0, 8'hff, r, ok);
		cmp8(r, ddpot_pkg::SAVED_RESET);
		$display("test saved done");
	endtask : t_saved
	task automatic t_wp;
		logic [7:0] r;
		logic       ok;
		@(posedge clk) wp_n <= 1'b0;
		op(ddpot_pkg::OP_WR_SAVED, 2'd3, 1'b0, 8'h11, r, ok);
		cmp1(nv_busy, 1'b0);
		op(ddpot_pkg::OP_RD_SAVED, 2'd3, 1'b0, 8'hff, r, ok);
		cmp8(r, ddpot_pkg::SAVED_RESET);
		@(posedge clk) wp_n <= 1'b1;
		$display("test protect done");
	endtask : t_wp
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_reset;
		t_wiper;
		t_addr;
		t_saved;
		t_wp;
		print_verdict;
	end
	// The tests need roughly a third of this span.
	initial begin
		#600000;
		errors++;
		print_verdict;
	end
endmodule : ddpot_slave_tb
